// ---- gst_pkg.sv ----
// constants, field positions and types of the gated 16-bit timer
package gst_pkg;

	// register byte offsets
	localparam logic [7:0] OFF_CONTROL      = 8'h00;
	localparam logic [7:0] OFF_GATE_CONTROL = 8'h04;
	localparam logic [7:0] OFF_COUNT_PAIR   = 8'h08;
	localparam logic [7:0] OFF_CAPCMP_PAIR  = 8'h0C;
	localparam logic [7:0] OFF_FLAGS        = 8'h10;
	localparam logic [7:0] OFF_CC_MODE      = 8'h14;

	// timer_control fields
	localparam int CTL_CS_HI   = 7;
	localparam int CTL_CS_LO   = 6;
	localparam int CTL_PS_HI   = 5;
	localparam int CTL_PS_LO   = 4;
	localparam int CTL_OSC_EN  = 3;
	localparam int CTL_SYNC_N  = 2;
	localparam int CTL_UNUSED  = 1;
	localparam int CTL_ON      = 0;

	// timer_gate_control fields
	localparam int GCT_ENABLE  = 7;
	localparam int GCT_POL     = 6;
	localparam int GCT_TOGGLE  = 5;
	localparam int GCT_SPM     = 4;
	localparam int GCT_GO_DONE = 3;
	localparam int GCT_VALUE   = 2;
	localparam int GCT_SS_HI   = 1;
	localparam int GCT_SS_LO   = 0;

	// flag and capture/compare mode fields
	localparam int FLG_OVERFLOW = 0;
	localparam int FLG_GATE_EVT = 1;
	localparam int FLG_CC_EVT   = 2;
	localparam int CC_CAPTURE   = 0;
	localparam int CC_COMPARE   = 1;
	localparam int CC_SPECIAL   = 2;

	// reset values and count maximum
	localparam logic [7:0]  RST_CONTROL = 8'h00;
	localparam logic [7:0]  RST_GATE    = 8'h00;
	localparam logic [15:0] RST_COUNT   = 16'h0000;
	localparam logic [15:0] RST_CAPCMP  = 16'h0000;
	localparam logic [15:0] COUNT_MAX   = 16'hFFFF;

	// instruction clock is the system clock divided by four
	localparam int          INSTR_DIV    = 4;
	localparam logic [1:0]  INSTR_DIV_LAST = 2'(INSTR_DIV - 1);

	// clock source codes
	localparam logic [1:0] CS_INSTR = 2'h0;
	localparam logic [1:0] CS_SYS   = 2'h1;
	localparam logic [1:0] CS_PIN   = 2'h2;
	localparam logic [1:0] CS_CAPS  = 2'h3;

	// gate source codes
	localparam logic [1:0] GS_PIN   = 2'h0;
	localparam logic [1:0] GS_TMRA  = 2'h1;
	localparam logic [1:0] GS_T2    = 2'h2;
	localparam logic [1:0] GS_WDT   = 2'h3;

	// single-pulse acquisition states
	typedef enum logic [1:0] {
		SP_IDLE  = 2'b00,
		SP_ARMED = 2'b01,
		SP_RUN   = 2'b10
	} gst_sp_state_t;

endpackage

// ---- gst_prescaler.sv ----
// input prescaler: passes one of every 1, 2, 4 or 8 source ticks
`timescale 1ns/10ps
module gst_prescaler
#(
	parameter int PS_W = 3
)
(
	// clock and reset
	input  wire logic            clk,
	input  wire logic            rst_n,
	// control
	input  wire logic            clear,
	input  wire logic [1:0]      prescaleSel,
	// ticks
	input  wire logic            srcTick,
	output logic                 outTick
);

	generate
		if (PS_W < 3)
		begin : g_chk
			$error("gst_prescaler: PS_W must reach 1:8");
		end
	endgenerate

	logic [PS_W-1:0] cnt_q;
	logic [PS_W-1:0] cnt_d;
	logic [PS_W-1:0] mask;

	assign mask    = PS_W'((1 << prescaleSel) - 1);
	assign outTick = srcTick && ((cnt_q & mask) == mask);
	assign cnt_d   = clear ? '0 : (srcTick ? cnt_q + 1'b1 : cnt_q);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

endmodule // gst_prescaler

// ---- gst_timer.sv ----
// gated 16-bit timer with capture/compare time base and APB registers
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/10ps

// Functional notes
// - capture event copies the whole count into the capture pair
// - compare event raised when compare pair equals the count
// - special event clears count without setting the overflow flag
// - with special event on, compare pair acts as the period
// - software count write beats a simultaneous special event clear
// - clock source: 11 cap-sense, 10 pin or crystal, 01 Fosc, 00 Fosc/4
// - prescale field divides by 1, 2, 4 or 8
// - oscillator-enable bit switches the low-power oscillator on or off
// - sync bit chooses sync or not for sources 1X, ignored otherwise
// - on bit enables counting; off stops count and clears toggle flop
// - gate-enable qualifies counting only while the timer is on
// - polarity bit selects active-high or active-low gate
// - toggle mode routes gate through a rising-edge toggle flop
// - single-pulse bit hands gate control to single-pulse acquisition
// - go/done reads 1 while armed; cleared when single-pulse is off
// - gate value bit shows the qualifying gate regardless of enable
// - gate source: pin, 8-bit overflow, timer-2 match, watchdog
// - watchdog oscillator on when gate enabled with watchdog source
// - control bits reset to zero; unimplemented bit reads zero
// - count rolls from all ones to zero and sets overflow flag
// - armed pulse counts from next rising edge, done on trailing edge
// - falling edge of gate value sets the gate event flag
module gst_timer
#(
	parameter int ADDR_W = 8
)
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// clock sources
	input  wire logic              extClockPin,
	input  wire logic              lpOscClock,
	input  wire logic              capSenseOsc,
	// gate sources
	input  wire logic              gatePin,
	input  wire logic              timerAOverflow,
	input  wire logic              t2PeriodMatch,
	input  wire logic              wdtOverflow,
	// capture/compare unit
	input  wire logic              captureEvent,
	output logic                   compareEvent,
	// status and oscillator control
	output logic      [15:0]       countValue,
	output logic                   overflowFlag,
	output logic                   gateEventFlag,
	output logic                   lpOscEnable,
	output logic                   wdtOscEnable
);

	generate
		if (ADDR_W < 5)
		begin : g_chk
			$error("gst_timer: ADDR_W too small for the register map");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// state

	logic [7:0]                  ctrl_q;
	logic [7:0]                  gctrl_q;
	logic [2:0]                  ccMode_q;
	logic [15:0]                 count_q;
	logic [15:0]                 count_d;
	logic [15:0]                 capCmp_q;
	logic [15:0]                 capCmp_d;
	logic [2:0]                  flags_q;
	logic [2:0]                  flags_d;
	gst_pkg::gst_sp_state_t      spState_q;
	gst_pkg::gst_sp_state_t      spState_d;
	logic [1:0]                  instrDiv_q;
	logic                        extRaw_q;
	logic                        extRawPrev_q;
	logic                        extSync1_q;
	logic                        extSync2_q;
	logic                        extSync3_q;
	logic                        polPrev_q;
	logic                        toggle_q;
	logic                        stagePrev_q;
	logic                        gateVal_q;
	logic                        equal_q;
	logic                        compareEvent_q;
	logic                        wdtOsc_q;
	logic [31:0]                 prdata_q;
	logic                        pready_q;
	logic                        pslverr_q;

	////////////////////////////////////////////////////////////////////////////
	// apb decode

	logic [7:0]  addrByte;
	logic        setupPhase;
	logic        wrEn;
	logic        hitCtrl;
	logic        hitGate;
	logic        hitCount;
	logic        hitCapCmp;
	logic        hitFlags;
	logic        hitMode;
	logic        mapped;
	logic [31:0] readMux;

	assign addrByte   = 8'(paddr);
	assign setupPhase = psel && !penable;
	assign wrEn       = psel && penable && pready_q && pwrite && !pslverr_q;
	assign hitCtrl    = addrByte == gst_pkg::OFF_CONTROL;
	assign hitGate    = addrByte == gst_pkg::OFF_GATE_CONTROL;
	assign hitCount   = addrByte == gst_pkg::OFF_COUNT_PAIR;
	assign hitCapCmp  = addrByte == gst_pkg::OFF_CAPCMP_PAIR;
	assign hitFlags   = addrByte == gst_pkg::OFF_FLAGS;
	assign hitMode    = addrByte == gst_pkg::OFF_CC_MODE;
	assign mapped     = hitCtrl || hitGate || hitCount || hitCapCmp || hitFlags || hitMode;

	logic        goDone;
	logic [7:0]  gateReadback;
	logic [7:0]  ctrlReadback;

	assign goDone       = spState_q != gst_pkg::SP_IDLE;
	assign ctrlReadback = ctrl_q & ~(8'h01 << gst_pkg::CTL_UNUSED);
	assign gateReadback = {gctrl_q[7:4], goDone, gateVal_q, gctrl_q[1:0]};

	assign readMux = hitCtrl   ? {24'h000000, ctrlReadback} :
	                 hitGate   ? {24'h000000, gateReadback} :
	                 hitCount  ? {16'h0000, count_q} :
	                 hitCapCmp ? {16'h0000, capCmp_q} :
	                 hitFlags  ? {29'h0, flags_q} :
	                 hitMode   ? {29'h0, ccMode_q} : 32'h00000000;

	// no wait state: data and response latched in the setup cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prdata_q  <= 32'h00000000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q  <= setupPhase;
			pslverr_q <= setupPhase && !mapped;
			if (setupPhase)
				prdata_q <= pwrite ? 32'h00000000 : readMux;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	////////////////////////////////////////////////////////////////////////////
	// control registers

	logic wrCtrl;
	logic wrGate;
	logic wrMode;
	logic wrFlags;

	assign wrCtrl  = wrEn && hitCtrl && pstrb[0];
	assign wrGate  = wrEn && hitGate && pstrb[0];
	assign wrMode  = wrEn && hitMode && pstrb[0];
	assign wrFlags = wrEn && hitFlags && pstrb[0];

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_q    <= gst_pkg::RST_CONTROL;
			gctrl_q   <= gst_pkg::RST_GATE;
			ccMode_q  <= 3'h0;
		end
		else
		begin
			if (wrCtrl)
				ctrl_q <= pwdata[7:0] & ~(8'h01 << gst_pkg::CTL_UNUSED);
			if (wrGate)
				gctrl_q <= pwdata[7:0] & 8'hF3;
			if (wrMode)
				ccMode_q <= pwdata[2:0];
		end
	end

	logic       timerOn;
	logic [1:0] clkSel;
	logic [1:0] gateSel;

	assign timerOn = ctrl_q[gst_pkg::CTL_ON];
	assign clkSel  = ctrl_q[gst_pkg::CTL_CS_HI:gst_pkg::CTL_CS_LO];
	assign gateSel = gctrl_q[gst_pkg::GCT_SS_HI:gst_pkg::GCT_SS_LO];

	////////////////////////////////////////////////////////////////////////////
	// clock source and prescaler

	logic srcLevel;
	logic rawEdge;
	logic syncEdge;
	logic pinEdge;
	logic instrTick;
	logic srcTick;
	logic countTick;

	// crystal replaces the pin when the low-power oscillator is enabled
	assign srcLevel  = (clkSel == gst_pkg::CS_CAPS) ? capSenseOsc :
	                   ctrl_q[gst_pkg::CTL_OSC_EN] ? lpOscClock : extClockPin;
	assign rawEdge   = extRaw_q && !extRawPrev_q;
	assign syncEdge  = extSync2_q && !extSync3_q;
	assign pinEdge   = ctrl_q[gst_pkg::CTL_SYNC_N] ? rawEdge : syncEdge;
	assign instrTick = instrDiv_q == gst_pkg::INSTR_DIV_LAST;
	assign srcTick   = (clkSel == gst_pkg::CS_INSTR) ? instrTick :
	                   (clkSel == gst_pkg::CS_SYS)   ? 1'b1 : pinEdge;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			instrDiv_q   <= 2'h0;
			extRaw_q     <= 1'b0;
			extRawPrev_q <= 1'b0;
			extSync1_q   <= 1'b0;
			extSync2_q   <= 1'b0;
			extSync3_q   <= 1'b0;
		end
		else
		begin
			instrDiv_q   <= instrDiv_q + 2'h1;
			extRaw_q     <= srcLevel;
			extRawPrev_q <= extRaw_q;
			extSync1_q   <= srcLevel;
			extSync2_q   <= extSync1_q;
			extSync3_q   <= extSync2_q;
		end
	end

	gst_prescaler #(
		.PS_W (3)
	) u_prescaler (
		.clk         (clk),
		.rst_n       (rst_n),
		.clear       (!timerOn),
		.prescaleSel (ctrl_q[gst_pkg::CTL_PS_HI:gst_pkg::CTL_PS_LO]),
		.srcTick     (srcTick),
		.outTick     (countTick)
	);

	////////////////////////////////////////////////////////////////////////////
	// gate unit

	logic gateRaw;
	logic gatePol;
	logic polRise;
	logic gateStage;
	logic stageRise;
	logic stageFall;
	logic gateQual;
	logic spMode;
	logic armWrite;

	assign gateRaw   = (gateSel == gst_pkg::GS_PIN)  ? gatePin :
	                   (gateSel == gst_pkg::GS_TMRA) ? timerAOverflow :
	                   (gateSel == gst_pkg::GS_T2)   ? t2PeriodMatch : wdtOverflow;
	assign gatePol   = gctrl_q[gst_pkg::GCT_POL] ? gateRaw : !gateRaw;
	assign polRise   = gatePol && !polPrev_q;
	assign gateStage = gctrl_q[gst_pkg::GCT_TOGGLE] ? toggle_q : gatePol;
	assign stageRise = gateStage && !stagePrev_q;
	assign stageFall = !gateStage && stagePrev_q;
	assign spMode    = gctrl_q[gst_pkg::GCT_SPM];
	assign armWrite  = wrGate && pwdata[gst_pkg::GCT_GO_DONE] && pwdata[gst_pkg::GCT_SPM];
	// in single-pulse mode only the captured pulse qualifies the count
	assign gateQual  = spMode ? (spState_q == gst_pkg::SP_RUN) : gateStage;

	always_comb
	begin
		spState_d = spState_q;
		case (spState_q)
			gst_pkg::SP_IDLE:
				if (armWrite)
					spState_d = gst_pkg::SP_ARMED;
			gst_pkg::SP_ARMED:
				if (stageRise)
					spState_d = gst_pkg::SP_RUN;
			gst_pkg::SP_RUN:
				if (stageFall)
					spState_d = gst_pkg::SP_IDLE;
			default:
				spState_d = gst_pkg::SP_IDLE;
		endcase
		if (wrGate && !pwdata[gst_pkg::GCT_GO_DONE])
			spState_d = gst_pkg::SP_IDLE;
		if (!spMode && !armWrite)
			spState_d = gst_pkg::SP_IDLE;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			polPrev_q   <= 1'b0;
			toggle_q    <= 1'b0;
			stagePrev_q <= 1'b0;
			gateVal_q   <= 1'b0;
			spState_q   <= gst_pkg::SP_IDLE;
			wdtOsc_q    <= 1'b0;
		end
		else
		begin
			polPrev_q   <= gatePol;
			stagePrev_q <= gateStage;
			spState_q   <= spState_d;
			gateVal_q   <= gateQual;
			if (!timerOn || !gctrl_q[gst_pkg::GCT_TOGGLE])
				toggle_q <= 1'b0;
			else if (polRise)
				toggle_q <= !toggle_q;
			wdtOsc_q    <= gctrl_q[gst_pkg::GCT_ENABLE] && (gateSel == gst_pkg::GS_WDT);
		end
	end

	assign lpOscEnable  = ctrl_q[gst_pkg::CTL_OSC_EN];
	assign wdtOscEnable = wdtOsc_q;

	////////////////////////////////////////////////////////////////////////////
	// count, capture and compare

	logic [15:0] countMerged;
	logic [15:0] capCmpMerged;
	logic        wrCount;
	logic        wrCapCmp;
	logic        countWritten;
	logic        capCmpWritten;
	logic        incEnable;
	logic        incTick;
	logic        equalNow;
	logic        matchPulse;
	logic        specialClear;
	logic        captureNow;
	logic        overflowSet;

	assign wrCount  = wrEn && hitCount;
	assign wrCapCmp = wrEn && hitCapCmp;

	genvar lane;
	generate
		for (lane = 0; lane < 2; lane++)
		begin : g_lane
			assign countMerged[lane*8 +: 8]  = (wrCount && pstrb[lane]) ?
			                                   pwdata[lane*8 +: 8] : count_q[lane*8 +: 8];
			assign capCmpMerged[lane*8 +: 8] = (wrCapCmp && pstrb[lane]) ?
			                                   pwdata[lane*8 +: 8] : capCmp_q[lane*8 +: 8];
		end
	endgenerate

	assign countWritten  = wrCount && (pstrb[1:0] != 2'h0);
	assign capCmpWritten = wrCapCmp && (pstrb[1:0] != 2'h0);
	// gate enable only matters while the timer is on
	assign incEnable     = timerOn && (!gctrl_q[gst_pkg::GCT_ENABLE] || gateVal_q);
	assign incTick       = incEnable && countTick;
	assign equalNow      = count_q == capCmp_q;
	assign matchPulse    = ccMode_q[gst_pkg::CC_COMPARE] && equalNow && !equal_q;
	assign specialClear  = matchPulse && ccMode_q[gst_pkg::CC_SPECIAL];
	assign captureNow    = ccMode_q[gst_pkg::CC_CAPTURE] && captureEvent;
	assign overflowSet   = incTick && !countWritten && !specialClear &&
	                       (count_q == gst_pkg::COUNT_MAX);

	always_comb
	begin
		if (countWritten)
			count_d = countMerged;
		else if (specialClear)
			count_d = 16'h0000;
		else if (incTick)
			count_d = count_q + 16'h0001;
		else
			count_d = count_q;
	end

	// software write to the pair beats a capture in the same cycle
	assign capCmp_d = capCmpWritten ? capCmpMerged :
	                  captureNow ? count_q : capCmp_q;

	// flags: hardware set wins over a write-one clear
	assign flags_d[gst_pkg::FLG_OVERFLOW] = overflowSet ||
		(flags_q[gst_pkg::FLG_OVERFLOW] && !(wrFlags && pwdata[gst_pkg::FLG_OVERFLOW]));
	assign flags_d[gst_pkg::FLG_GATE_EVT] = (gateVal_q && !gateQual) ||
		(flags_q[gst_pkg::FLG_GATE_EVT] && !(wrFlags && pwdata[gst_pkg::FLG_GATE_EVT]));
	assign flags_d[gst_pkg::FLG_CC_EVT]   = matchPulse || captureNow ||
		(flags_q[gst_pkg::FLG_CC_EVT] && !(wrFlags && pwdata[gst_pkg::FLG_CC_EVT]));

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_q        <= gst_pkg::RST_COUNT;
			capCmp_q       <= gst_pkg::RST_CAPCMP;
			flags_q        <= 3'h0;
			equal_q        <= 1'b0;
			compareEvent_q <= 1'b0;
		end
		else
		begin
			count_q        <= count_d;
			capCmp_q       <= capCmp_d;
			flags_q        <= flags_d;
			equal_q        <= equalNow;
			compareEvent_q <= matchPulse;
		end
	end

	assign countValue    = count_q;
	assign compareEvent  = compareEvent_q;
	assign overflowFlag  = flags_q[gst_pkg::FLG_OVERFLOW];
	assign gateEventFlag = flags_q[gst_pkg::FLG_GATE_EVT];

endmodule // gst_timer

// ---- gst_timer_monitor.sv ----
// port-level assertion checker for the gated 16-bit timer
`timescale 1ns/10ps
module gst_timer_monitor
#(
	parameter int ADDR_W = 8
)
(
	// clock and reset
	input wire logic              clk,
	input wire logic              rst_n,
	// apb
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [3:0]        pstrb,
	input wire logic              pready,
	input wire logic              pslverr,
	// status
	input wire logic [15:0]       countValue,
	input wire logic              overflowFlag,
	input wire logic              compareEvent,
	input wire logic              lpOscEnable,
	input wire logic              wdtOscEnable
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic apbWr;
	assign apbWr = psel && penable && pwrite && pready;
	////////////////////////////////////////////////////////////////////////////
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_wrTo(logic [7:0] a);
		apbWr && paddr == ADDR_W'(a);
	endsequence
	sequence s_wrap;
		countValue == 16'hFFFF ##1 countValue == 16'h0000;
	endsequence
	////////////////////////////////////////////////////////////////////////////
	property p_ready; s_setup |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("ready missing after setup");
	property p_readyPulse; pready |=> !pready; endproperty
	a_readyPulse: assert property (p_readyPulse) else $error("ready held too long");
	property p_errMap; s_setup ##0 paddr > ADDR_W'(gst_pkg::OFF_CC_MODE) |=> pslverr; endproperty
	a_errMap: assert property (p_errMap) else $error("unmapped access not refused");
	property p_lpOsc; s_wrTo(gst_pkg::OFF_CONTROL) ##0 pstrb[0] |=> lpOscEnable == $past(pwdata[3]);
	endproperty
	a_lpOsc: assert property (p_lpOsc) else $error("oscillator enable wrong");
	property p_wdtOsc;
		s_wrTo(gst_pkg::OFF_GATE_CONTROL) ##0 pstrb[0]
			|=> ##1 wdtOscEnable == $past(pwdata[7] && pwdata[1:0] == 2'h3, 2);
	endproperty
	a_wdtOsc: assert property (p_wdtOsc) else $error("watchdog oscillator wrong");
	property p_step;
		countValue != $past(countValue)
			|-> countValue == $past(countValue) + 16'h0001 || countValue == 16'h0000 || $past(apbWr);
	endproperty
	a_step: assert property (p_step) else $error("count jumped");
	property p_wrap; s_wrap |-> ##[0:1] overflowFlag; endproperty
	a_wrap: assert property (p_wrap) else $error("rollover without flag");
	property p_sticky;
		overflowFlag && !(apbWr && paddr == ADDR_W'(gst_pkg::OFF_FLAGS) && pwdata[0]) |=> overflowFlag;
	endproperty
	a_sticky: assert property (p_sticky) else $error("overflow flag lost");
	property p_cmpPulse; compareEvent |=> !compareEvent; endproperty
	a_cmpPulse: assert property (p_cmpPulse) else $error("compare pulse too long");
	property p_reset; $rose(rst_n) |-> countValue == 16'h0000 && !overflowFlag && !compareEvent;
	endproperty
	a_reset: assert property (p_reset) else $error("outputs not clear after reset");
endmodule // gst_timer_monitor

bind gst_timer gst_timer_monitor #(.ADDR_W(ADDR_W)) u_mon (.clk, .rst_n, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .countValue, .overflowFlag,
	.compareEvent, .lpOscEnable, .wdtOscEnable);

// ---- gst_partner.sv ----
// far-side model: oscillators, gate sources and capture requests
`timescale 1ns/10ps
module gst_partner
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// commands from the bench
	input  wire logic [1:0] gateSel,
	input  wire logic       gateLvl,
	input  wire logic       capReq,
	// toward the timer
	output logic            extClockPin,
	output logic            lpOscClock,
	output logic            capSenseOsc,
	output logic [3:0]      gateSrc,
	output logic            captureEvent
);
	logic [4:0] divCnt_q;
	// oscillators run free with periods of 8, 16 and 32 clocks
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			divCnt_q <= 5'h00;
		else
			divCnt_q <= divCnt_q + 5'h01;
	assign extClockPin  = divCnt_q[2];
	assign lpOscClock   = divCnt_q[3];
	assign capSenseOsc  = divCnt_q[4];
	// only the selected gate source moves, the others stay low
	assign gateSrc      = gateLvl ? 4'h1 << gateSel : 4'h0;
	assign captureEvent = capReq;
endmodule // gst_partner

// ---- gst_timer_tb.sv ----
// self-checking bench for the gated 16-bit timer
`timescale 1ns/10ps
module gst_timer_tb;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} gst_row_t;
	logic        clk, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        pready, pslverr, errSeen, capReq = 1'b0, gateLvl = 1'b0;
	logic [1:0]  gateSel = 2'h0;
	logic        extClockPin, lpOscClock, capSenseOsc, captureEvent;
	logic [3:0]  gateSrc;
	logic        compareEvent, overflowFlag, gateEventFlag;
	logic [15:0] countValue, d, c;
	int          err_count = 0, cmp_count = 0, pulses;
	gst_row_t    rows[6] = '{'{gst_pkg::OFF_CONTROL, 32'hFE, 32'hFC, 1'b0},
		'{gst_pkg::OFF_GATE_CONTROL, 32'hC7, 32'hC3, 1'b0},
		'{gst_pkg::OFF_CAPCMP_PAIR, 32'hA55A, 32'hA55A, 1'b0},
		'{gst_pkg::OFF_COUNT_PAIR, 32'h1234, 32'h1234, 1'b0},
		'{8'h20, 32'h1, 32'h0, 1'b1},
		'{gst_pkg::OFF_GATE_CONTROL, 32'h0, 32'h4, 1'b0}};
	// clock modes: instr, sys, pin synced, pin unsynced, crystal, cap-sense
	logic [7:0]  modeCtl[6] = '{8'h01, 8'h41, 8'h81, 8'h85, 8'h89, 8'hC1};
	int          modeDiv[6] = '{4, 1, 8, 8, 16, 32};

	gst_timer #(.ADDR_W(8)) dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'hF), .prdata, .pready, .pslverr, .extClockPin, .lpOscClock, .capSenseOsc,
		.gatePin(gateSrc[0]), .timerAOverflow(gateSrc[1]), .t2PeriodMatch(gateSrc[2]),
		.wdtOverflow(gateSrc[3]), .captureEvent, .compareEvent, .countValue, .overflowFlag,
		.gateEventFlag, .lpOscEnable(), .wdtOscEnable());
	gst_partner partner (.clk, .rst_n, .gateSel, .gateLvl, .capReq, .extClockPin, .lpOscClock,
		.capSenseOsc, .gateSrc, .captureEvent);
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// one apb transfer, entered just after a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dat;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		errSeen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic meas(input int k);
		c = countValue;
		repeat (k) @(posedge clk);
		d = countValue - c;
	endtask
	task automatic pulse(input int n);
		gateLvl <= 1'b1;
		repeat (n) @(posedge clk);
		gateLvl <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		stop_test();
	end
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (rows[i])
		begin
			apb(1'b1, rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 32'h0);
			check("reg read", q, rows[i].q);
			check("reg error", 32'(errSeen), 32'(rows[i].e));
		end
		$display("register rows done");
		foreach (modeCtl[m])
			for (int p = 0; p < 4; p++)
			begin
				apb(1'b1, gst_pkg::OFF_CONTROL, 32'(modeCtl[m] | 8'(p << 4)));
				repeat (16) @(posedge clk);
				meas(256);
				check("tick rate", 32'(d), 32'(256 / (modeDiv[m] << p)));
			end
		$display("clock and prescale done");
		apb(1'b1, gst_pkg::OFF_CONTROL, 32'h41);
		for (int s = 0; s < 4; s++)
		begin
			gateSel <= 2'(s);
			apb(1'b1, gst_pkg::OFF_GATE_CONTROL, 32'hC0 | 32'(s));
			repeat (6) @(posedge clk);
			meas(32);
			check("gate closed", 32'(d), 32'h0);
			gateLvl <= 1'b1;
			repeat (6) @(posedge clk);
			meas(32);
			check("gate open", 32'(d), 32'd32);
			apb(1'b0, gst_pkg::OFF_GATE_CONTROL, 32'h0);
			check("gate value", 32'(q[gst_pkg::GCT_VALUE]), 32'h1);
			gateLvl <= 1'b0;
			repeat (6) @(posedge clk);
			check("gate event", 32'(gateEventFlag), 32'h1);
			apb(1'b1, gst_pkg::OFF_FLAGS, 32'h7);
			check("gate event clear", 32'(gateEventFlag), 32'h0);
		end
		gateSel <= 2'h0;
		apb(1'b1, gst_pkg::OFF_GATE_CONTROL, 32'h80);
		repeat (6) @(posedge clk);
		meas(32);
		check("active low gate", 32'(d), 32'd32);
		apb(1'b1, gst_pkg::OFF_GATE_CONTROL, 32'hE0);
		pulse(3);
		meas(32);
		check("toggle held", 32'(d), 32'd32);
		apb(1'b1, gst_pkg::OFF_CONTROL, 32'h40);
		meas(32);
		check("timer off", 32'(d), 32'h0);
		apb(1'b1, gst_pkg::OFF_CONTROL, 32'h41);
		meas(32);
		check("toggle cleared", 32'(d), 32'h0);
		$display("gate tests done");
		apb(1'b1, gst_pkg::OFF_GATE_CONTROL, 32'hD8);
		apb(1'b0, gst_pkg::OFF_GATE_CONTROL, 32'h0);
		check("armed", 32'(q[gst_pkg::GCT_GO_DONE]), 32'h1);
		c = countValue;
		pulse(20);
		check("pulse counted", 32'(countValue != c), 32'h1);
		apb(1'b0, gst_pkg::OFF_GATE_CONTROL, 32'h0);
		check("done", 32'(q[gst_pkg::GCT_GO_DONE]), 32'h0);
		c = countValue;
		pulse(20);
		check("second pulse", 32'(countValue), 32'(c));
		apb(1'b1, gst_pkg::OFF_GATE_CONTROL, 32'hD8);
		apb(1'b1, gst_pkg::OFF_GATE_CONTROL, 32'hC8);
		apb(1'b0, gst_pkg::OFF_GATE_CONTROL, 32'h0);
		check("go cleared", 32'(q[gst_pkg::GCT_GO_DONE]), 32'h0);
		$display("single pulse done");
		apb(1'b1, gst_pkg::OFF_CONTROL, 32'h0);
		apb(1'b1, gst_pkg::OFF_GATE_CONTROL, 32'h0);
		apb(1'b1, gst_pkg::OFF_FLAGS, 32'h7);
		apb(1'b1, gst_pkg::OFF_COUNT_PAIR, 32'hFFF0);
		apb(1'b1, gst_pkg::OFF_CONTROL, 32'h41);
		repeat (40) @(posedge clk);
		check("overflow", 32'(overflowFlag), 32'h1);
		apb(1'b1, gst_pkg::OFF_FLAGS, 32'h1);
		check("overflow clear", 32'(overflowFlag), 32'h0);
		$display("overflow done");
		apb(1'b1, gst_pkg::OFF_CONTROL, 32'h0);
		apb(1'b1, gst_pkg::OFF_COUNT_PAIR, 32'h0);
		apb(1'b1, gst_pkg::OFF_CAPCMP_PAIR, 32'h10);
		apb(1'b1, gst_pkg::OFF_CC_MODE, 32'h6);
		apb(1'b1, gst_pkg::OFF_CONTROL, 32'h41);
		pulses = 0;
		c = 16'h0000;
		repeat (120)
		begin
			@(posedge clk);
			pulses += int'(compareEvent);
			c = (countValue > c) ? countValue : c;
		end
		check("period top", 32'(c), 32'h10);
		check("no overflow", 32'(overflowFlag), 32'h0);
		check("compare pulses", 32'(pulses >= 6), 32'h1);
		apb(1'b1, gst_pkg::OFF_CONTROL, 32'h0);
		apb(1'b1, gst_pkg::OFF_CC_MODE, 32'h1);
		apb(1'b1, gst_pkg::OFF_COUNT_PAIR, 32'h4321);
		capReq <= 1'b1;
		@(posedge clk);
		capReq <= 1'b0;
		@(posedge clk);
		apb(1'b0, gst_pkg::OFF_CAPCMP_PAIR, 32'h0);
		check("capture", q, 32'h4321);
		$display("capture compare done");
		gateLvl <= 1'b1;
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// control, gate control and count all clear
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b0, 8'(4 * i), 32'h0);
			check("reset value", q, 32'h0);
		end
		$display("reset done");
		stop_test();
	end
endmodule // gst_timer_tb
